// ---- include/iexs_pkg.sv ----
// constants and types for the instruction execute subset block
// ========================================
package iexs_pkg;
  // ========================================
  // register map
  localparam logic [31:0] IEXS_OFF_CMD = 32'h0000_0000;
  localparam logic [31:0] IEXS_OFF_ACC = 32'h0000_0004;
  localparam logic [31:0] IEXS_OFF_STATUS = 32'h0000_0008;
  localparam logic [31:0] IEXS_OFF_PC = 32'h0000_000c;
  localparam logic [31:0] IEXS_OFF_STACK = 32'h0000_0010;
  localparam logic [31:0] IEXS_OFF_WDOG = 32'h0000_0014;
  localparam logic [31:0] IEXS_OFF_FADDR = 32'h0000_0018;
  localparam logic [31:0] IEXS_OFF_FDATA = 32'h0000_001c;
  localparam logic [1:0] IEXS_RESP_OKAY = 2'h0;
  localparam logic [1:0] IEXS_RESP_SLVERR = 2'h2;
  // ========================================
  // field layout and widths
  localparam int unsigned IEXS_CMD_W = 20;
  localparam int unsigned IEXS_FLAGS_W = 7;
  localparam int unsigned IEXS_PC_W = 13;
  localparam int unsigned IEXS_STACK_DEPTH = 8;
  localparam int unsigned IEXS_STATUS_BUSY_BIT = 7;
  localparam int unsigned IEXS_WDOG_PRE_LSB = 8;
  localparam int unsigned IEXS_STACK_PTR_LSB = 16;
  // ========================================
  // reset values
  localparam logic [7:0] IEXS_ACC_RST = 8'h00;
  localparam logic [12:0] IEXS_PC_RST = 13'h0000;
  localparam logic [6:0] IEXS_FLAGS_RST = 7'h18;
  localparam logic [7:0] IEXS_WDOG_CLR = 8'h00;
  // ========================================
  // types
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_LOAD_LIT = 4'h1, OP_RET_INT = 4'h2, OP_STORE = 4'h3,
    OP_RET_LIT = 4'h4, OP_RETURN = 4'h5, OP_ROT_L = 4'h6, OP_ROT_R = 4'h7,
    OP_SWAP = 4'h8, OP_SLEEP = 4'h9, OP_SUB_LIT = 4'ha, OP_SUB_FILE = 4'hb,
    OP_XOR_LIT = 4'hc, OP_XOR_FILE = 4'hd
  } iexs_op_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_SECOND = 2'b10} iexs_state_t;
  typedef struct packed {
    logic [7:0] literal;
    logic [6:0] addr;
    logic dest;
    iexs_op_t opcode;
  } iexs_cmd_t;
  typedef struct packed {
    logic sleeping;
    logic global_irq_enable;
    logic timeout_flag;
    logic powerdown_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } iexs_flags_t;
  typedef struct packed {
    logic [7:0] result;
    logic carry;
    logic digit_carry_flag;
    logic zero;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic wr_acc;
    logic wr_file;
  } iexs_alu_t;
endpackage

// ---- verilog/iexs_alu.sv ----
// datapath for the rotate, swap, subtract, xor and move operations
module iexs_alu import iexs_pkg::*; (
  input wire iexs_cmd_t cmd,
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire logic carry_in,
  output iexs_alu_t res
);
  // subtract with carry meaning no borrow
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    return {full[8], low[4], full[7:0]};
  endfunction

  logic [9:0] sub_r;
  always_comb begin
    sub_r = sub8((cmd.opcode == OP_SUB_LIT) ? cmd.literal : fval, acc);
    res = '0;
    unique case (cmd.opcode)
      OP_LOAD_LIT, OP_RET_LIT: begin res.result = cmd.literal; res.wr_acc = 1'b1; end
      OP_STORE: begin res.result = acc; res.wr_file = 1'b1; end
      OP_ROT_L: begin res.result = {fval[6:0], carry_in}; res.carry = fval[7]; res.upd_c = 1'b1; end
      OP_ROT_R: begin res.result = {carry_in, fval[7:1]}; res.carry = fval[0]; res.upd_c = 1'b1; end
      OP_SWAP: res.result = {fval[3:0], fval[7:4]};
      OP_SUB_LIT, OP_SUB_FILE: begin
        res.result = sub_r[7:0];
        res.carry = sub_r[9];
        res.digit_carry_flag = sub_r[8];
        {res.upd_c, res.upd_dc, res.upd_z} = 3'b111;
      end
      OP_XOR_LIT: begin res.result = acc ^ cmd.literal; res.upd_z = 1'b1; end
      OP_XOR_FILE: begin res.result = acc ^ fval; res.upd_z = 1'b1; end
      default: res.result = acc;
    endcase
    res.zero = (res.result == 8'h00);
    if (cmd.opcode inside {OP_ROT_L, OP_ROT_R, OP_SWAP, OP_SUB_FILE, OP_XOR_FILE}) begin
      res.wr_file = cmd.dest;
      res.wr_acc = !cmd.dest;
    end
    if (cmd.opcode inside {OP_SUB_LIT, OP_XOR_LIT}) begin
      res.wr_acc = 1'b1;
    end
  end
endmodule

// ---- verilog/iexs_stack.sv ----
// hardware return stack, circular, eight entries
module iexs_stack import iexs_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire logic [12:0] push_data,
  input wire logic pop,
  output logic [12:0] top_of_stack,
  output logic [2:0] ptr
);
  logic [12:0] mem [IEXS_STACK_DEPTH];
  logic [2:0] top_idx;

  assign top_idx = ptr - 3'd1;
  assign top_of_stack = mem[top_idx];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr <= 3'd0;
    end else if (push) begin
      ptr <= ptr + 3'd1;
    end else if (pop) begin
      ptr <= top_idx;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < IEXS_STACK_DEPTH; i++) begin
        mem[i] <= IEXS_PC_RST;
      end
    end else if (push) begin
      mem[ptr] <= push_data;
    end
  end
endmodule

// ---- verilog/iexs_core.sv ----
// instruction execute subset with axi4-lite register access
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
module iexs_core import iexs_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic osc_run
);
  // ========================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    return (a[31:5] == 27'h0) && (a[1:0] == 2'b00);
  endfunction

  // ========================================
  // state
  iexs_state_t state;
  iexs_cmd_t cmd;
  iexs_flags_t flags;
  iexs_alu_t alu;
  logic [7:0] acc;
  logic [12:0] pc;
  logic [7:0] file_mem [128];
  logic [6:0] faddr;
  logic [7:0] wdog;
  logic [7:0] wdog_pre;
  logic [7:0] fval;
  logic [12:0] stack_top;
  logic [2:0] stack_ptr;
  logic exec;
  logic is_ret;

  // ========================================
  // write channel
  logic aw_held;
  logic w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic bus_wr;
  logic [31:0] wr_val;

  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign bus_wr = wr_fire && mapped(aw_addr) && (state == ST_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= IEXS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= mapped(aw_addr) ? IEXS_RESP_OKAY : IEXS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ========================================
  // read channel
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= IEXS_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= mapped(araddr) ? IEXS_RESP_OKAY : IEXS_RESP_SLVERR;
      unique case (araddr)
        IEXS_OFF_CMD: rdata <= {12'h000, cmd};
        IEXS_OFF_ACC: rdata <= {24'h000000, acc};
        IEXS_OFF_STATUS: rdata <= {24'h000000, state != ST_IDLE, flags};
        IEXS_OFF_PC: rdata <= {19'h00000, pc};
        IEXS_OFF_STACK: rdata <= {13'h0000, stack_ptr, 3'h0, stack_top};
        IEXS_OFF_WDOG: rdata <= {16'h0000, wdog_pre, wdog};
        IEXS_OFF_FADDR: rdata <= {25'h0000000, faddr};
        IEXS_OFF_FDATA: rdata <= {24'h000000, file_mem[faddr]};
        default: rdata <= 32'h0000_0000;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ========================================
  // sequencing
  assign wr_val = merge(32'h0000_0000, w_data, w_strb);
  assign exec = (state == ST_EXEC);
  assign is_ret = cmd.opcode inside {OP_RET_INT, OP_RET_LIT, OP_RETURN};
  assign fval = file_mem[cmd.addr];
  assign osc_run = !flags.sleeping;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cmd <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (bus_wr && aw_addr == IEXS_OFF_CMD && !flags.sleeping) begin
            cmd <= iexs_cmd_t'(wr_val[IEXS_CMD_W-1:0]);
            state <= ST_EXEC;
          end
        end
        ST_EXEC: state <= is_ret ? ST_SECOND : ST_IDLE;
        ST_SECOND: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  iexs_alu u_alu (
    .cmd(cmd),
    .acc(acc),
    .fval(fval),
    .carry_in(flags.carry),
    .res(alu)
  );

  iexs_stack u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(bus_wr && aw_addr == IEXS_OFF_STACK),
    .push_data(wr_val[IEXS_PC_W-1:0]),
    .pop(exec && is_ret),
    .top_of_stack(stack_top),
    .ptr(stack_ptr)
  );

  // ========================================
  // architectural registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= IEXS_ACC_RST;
    end else if (exec && alu.wr_acc) begin
      acc <= alu.result;
    end else if (bus_wr && aw_addr == IEXS_OFF_ACC) begin
      acc <= wr_val[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc <= IEXS_PC_RST;
    end else if (exec) begin
      pc <= is_ret ? stack_top : pc + 13'd1;
    end else if (bus_wr && aw_addr == IEXS_OFF_PC) begin
      pc <= wr_val[IEXS_PC_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= iexs_flags_t'(IEXS_FLAGS_RST);
    end else if (exec) begin
      if (alu.upd_c) flags.carry <= alu.carry;
      if (alu.upd_dc) flags.digit_carry_flag <= alu.digit_carry_flag;
      if (alu.upd_z) flags.zero <= alu.zero;
      if (cmd.opcode == OP_RET_INT) flags.global_irq_enable <= 1'b1;
      if (cmd.opcode == OP_SLEEP) begin
        flags.timeout_flag <= 1'b1;
        flags.powerdown_flag <= 1'b0;
        flags.sleeping <= 1'b1;
      end
    end else if (bus_wr && aw_addr == IEXS_OFF_STATUS) begin
      flags <= iexs_flags_t'(wr_val[IEXS_FLAGS_W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faddr <= 7'h00;
    end else if (bus_wr && aw_addr == IEXS_OFF_FADDR) begin
      faddr <= wr_val[6:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 128; i++) begin
        file_mem[i] <= 8'h00;
      end
    end else if (exec && alu.wr_file) begin
      file_mem[cmd.addr] <= alu.result;
    end else if (bus_wr && aw_addr == IEXS_OFF_FDATA) begin
      file_mem[faddr] <= wr_val[7:0];
    end
  end

  // watchdog runs while awake and freezes asleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog <= IEXS_WDOG_CLR;
      wdog_pre <= IEXS_WDOG_CLR;
    end else if (exec && cmd.opcode == OP_SLEEP) begin
      wdog <= IEXS_WDOG_CLR;
      wdog_pre <= IEXS_WDOG_CLR;
    end else if (!flags.sleeping) begin
      wdog_pre <= wdog_pre + 8'd1;
      if (wdog_pre == 8'hff) wdog <= wdog + 8'd1;
    end
  end

  // ========================================
  // checks
  logic [7:0] past_fval;
  logic [7:0] past_acc;
  logic past_c;

  always_ff @(posedge aclk) begin
    past_fval <= fval;
    past_acc <= acc;
    past_c <= flags.carry;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_exec(iexs_op_t o);
    exec && cmd.opcode == o;
  endsequence
  sequence s_two_cycle;
    state == ST_SECOND ##1 state == ST_IDLE;
  endsequence
  sequence s_exec_dest(iexs_op_t o, logic d);
    exec && cmd.opcode == o && cmd.dest == d;
  endsequence

  property p_load_lit;
    s_exec(OP_LOAD_LIT) |=> acc == $past(cmd.literal) && $stable(flags);
  endproperty
  a_load_lit: assert property (p_load_lit) else $error("load literal wrong");
  property p_ret_int;
    s_exec(OP_RET_INT) |=> (pc == $past(stack_top) && flags.global_irq_enable) ##0 s_two_cycle;
  endproperty
  a_ret_int: assert property (p_ret_int) else $error("return from interrupt wrong");
  property p_store;
    s_exec(OP_STORE) |=> file_mem[$past(cmd.addr)] == past_acc && $stable(flags);
  endproperty
  a_store: assert property (p_store) else $error("store accumulator wrong");
  property p_ret_lit;
    s_exec(OP_RET_LIT) |=> (acc == $past(cmd.literal) && pc == $past(stack_top)) ##0 s_two_cycle;
  endproperty
  a_ret_lit: assert property (p_ret_lit) else $error("return with literal wrong");
  property p_return;
    s_exec(OP_RETURN) |=> (pc == $past(stack_top) && stack_ptr == $past(stack_ptr) - 3'd1
      && $stable(flags)) ##0 s_two_cycle;
  endproperty
  a_return: assert property (p_return) else $error("return wrong");
  property p_rot_l;
    s_exec_dest(OP_ROT_L, 1'b0) |=> acc == {past_fval[6:0], past_c} && flags.carry == past_fval[7]
      && flags.zero == $past(flags.zero);
  endproperty
  a_rot_l: assert property (p_rot_l) else $error("rotate left wrong");
  property p_rot_r;
    s_exec_dest(OP_ROT_R, 1'b1) |=> file_mem[$past(cmd.addr)] == {past_c, past_fval[7:1]}
      && flags.carry == past_fval[0];
  endproperty
  a_rot_r: assert property (p_rot_r) else $error("rotate right wrong");
  property p_dest_file;
    exec && cmd.dest && cmd.opcode inside {OP_ROT_L, OP_ROT_R, OP_SWAP, OP_SUB_FILE, OP_XOR_FILE}
      |=> $stable(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("destination file touched accumulator");
  property p_swap;
    s_exec_dest(OP_SWAP, 1'b0) |=> acc == {past_fval[3:0], past_fval[7:4]} && $stable(flags);
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap wrong");
  property p_sleep;
    s_exec(OP_SLEEP) |=> flags.timeout_flag && !flags.powerdown_flag && wdog == 8'h00
      && wdog_pre == 8'h00 && !osc_run;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_sub_lit;
    s_exec(OP_SUB_LIT) |=> acc == 8'($past(cmd.literal) - past_acc) && flags.carry == ($past(cmd.literal) >= past_acc)
      && flags.zero == (acc == 8'h00);
  endproperty
  a_sub_lit: assert property (p_sub_lit) else $error("subtract from literal wrong");
  property p_sub_file;
    s_exec_dest(OP_SUB_FILE, 1'b1) |=> file_mem[$past(cmd.addr)] == 8'(past_fval - past_acc)
      && flags.carry == (past_fval >= past_acc) && flags.digit_carry_flag == (past_fval[3:0] >= past_acc[3:0]);
  endproperty
  a_sub_file: assert property (p_sub_file) else $error("subtract from file wrong");
  property p_xor_lit;
    s_exec(OP_XOR_LIT) |=> acc == (past_acc ^ $past(cmd.literal)) && flags.zero == (acc == 8'h00)
      && flags.carry == past_c;
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("xor literal wrong");
  property p_xor_file;
    s_exec_dest(OP_XOR_FILE, 1'b0) |=> acc == (past_acc ^ past_fval) && flags.carry == past_c;
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("xor file wrong");
  property p_nop;
    s_exec(OP_NOP) |=> $stable(acc) && $stable(flags) && pc == $past(pc) + 13'd1 && state == ST_IDLE;
  endproperty
  a_nop: assert property (p_nop) else $error("no operation changed state");
endmodule

// ---- bench/iexs_core_bench.sv ----
// self-checking bench for the instruction execute subset core
module iexs_core_bench import iexs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ========================================
  // signals and instance
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, osc_run;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int checks_done = 0;
  iexs_core iexs_core_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .osc_run(osc_run));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ========================================
  // compare, bus and command tasks
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("rresp", {30'h0, IEXS_RESP_OKAY}, {30'h0, r});
    chk(nm, e, d);
  endtask
  task automatic ex(input iexs_op_t op, input logic d, input logic [6:0] a, input logic [7:0] k);
    iexs_cmd_t c;
    logic [31:0] s;
    logic [1:0] r;
    c.literal = k;
    c.addr = a;
    c.dest = d;
    c.opcode = op;
    wr(IEXS_OFF_CMD, {12'h0, c}, IEXS_RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      rd(IEXS_OFF_STATUS, s, r);
      if (s[IEXS_STATUS_BUSY_BIT] === 1'b0) break;
    end
    chk("busy", 32'h0, {31'h0, s[IEXS_STATUS_BUSY_BIT]});
  endtask
  // ========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk("acc", IEXS_OFF_ACC, 32'h0);
    rchk("status", IEXS_OFF_STATUS, 32'h18);
    rchk("pc", IEXS_OFF_PC, 32'h0);
    rd(32'h20, d, r);
    chk("rresp", {30'h0, IEXS_RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, d);
    wr(32'h20, 32'h1, IEXS_RESP_SLVERR);
  endtask
  task automatic t_load_store();
    wr(IEXS_OFF_STATUS, 32'h1f, IEXS_RESP_OKAY);
    ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'hff);
    rchk("acc", IEXS_OFF_ACC, 32'hff);
    rchk("status", IEXS_OFF_STATUS, 32'h1f);
    ex(OP_STORE, 1'b0, 7'h7f, 8'h00);
    wr(IEXS_OFF_FADDR, 32'h7f, IEXS_RESP_OKAY);
    rchk("file", IEXS_OFF_FDATA, 32'hff);
    rchk("status", IEXS_OFF_STATUS, 32'h1f);
  endtask
  task automatic t_rot_swap();
    wr(IEXS_OFF_FADDR, 32'h05, IEXS_RESP_OKAY);
    wr(IEXS_OFF_FDATA, 32'h81, IEXS_RESP_OKAY);
    wr(IEXS_OFF_STATUS, 32'h1e, IEXS_RESP_OKAY);
    ex(OP_ROT_L, 1'b0, 7'h05, 8'h00);
    rchk("acc", IEXS_OFF_ACC, 32'h02);
    rchk("file", IEXS_OFF_FDATA, 32'h81);
    rchk("status", IEXS_OFF_STATUS, 32'h1f);
    wr(IEXS_OFF_STATUS, 32'h1e, IEXS_RESP_OKAY);
    ex(OP_ROT_R, 1'b1, 7'h05, 8'h00);
    rchk("file", IEXS_OFF_FDATA, 32'h40);
    rchk("status", IEXS_OFF_STATUS, 32'h1f);
    wr(IEXS_OFF_FDATA, 32'ha5, IEXS_RESP_OKAY);
    wr(IEXS_OFF_STATUS, 32'h1a, IEXS_RESP_OKAY);
    ex(OP_SWAP, 1'b0, 7'h05, 8'h00);
    rchk("acc", IEXS_OFF_ACC, 32'h5a);
    ex(OP_SWAP, 1'b1, 7'h05, 8'h00);
    rchk("file", IEXS_OFF_FDATA, 32'h5a);
    rchk("status", IEXS_OFF_STATUS, 32'h1a);
  endtask
  task automatic alu_case(input iexs_op_t op, input logic [7:0] a, input logic [7:0] f, input logic [7:0] k,
                          input logic [7:0] pre, input logic [7:0] res, input logic [7:0] post);
    wr(IEXS_OFF_FADDR, 32'h05, IEXS_RESP_OKAY);
    wr(IEXS_OFF_FDATA, {24'h0, f}, IEXS_RESP_OKAY);
    wr(IEXS_OFF_ACC, {24'h0, a}, IEXS_RESP_OKAY);
    wr(IEXS_OFF_STATUS, {24'h0, pre}, IEXS_RESP_OKAY);
    ex(op, 1'b0, 7'h05, k);
    rchk("acc", IEXS_OFF_ACC, {24'h0, res});
    rchk("status", IEXS_OFF_STATUS, {24'h0, post});
  endtask
  task automatic t_arith();
    alu_case(OP_SUB_LIT, 8'h01, 8'h00, 8'h01, 8'h18, 8'h00, 8'h1f);
    alu_case(OP_SUB_LIT, 8'h02, 8'h00, 8'h01, 8'h1f, 8'hff, 8'h18);
    alu_case(OP_SUB_FILE, 8'h01, 8'h10, 8'h00, 8'h18, 8'h0f, 8'h19);
    alu_case(OP_SUB_FILE, 8'h00, 8'hff, 8'h00, 8'h18, 8'hff, 8'h1b);
    alu_case(OP_XOR_LIT, 8'h5a, 8'h00, 8'h5a, 8'h1b, 8'h00, 8'h1f);
    alu_case(OP_XOR_FILE, 8'h0f, 8'hf0, 8'h00, 8'h1f, 8'hff, 8'h1b);
    wr(IEXS_OFF_ACC, 32'h01, IEXS_RESP_OKAY);
    ex(OP_SUB_FILE, 1'b1, 7'h05, 8'h00);
    rchk("file", IEXS_OFF_FDATA, 32'hef);
    rchk("acc", IEXS_OFF_ACC, 32'h01);
  endtask
  task automatic t_returns();
    wr(IEXS_OFF_STATUS, 32'h18, IEXS_RESP_OKAY);
    wr(IEXS_OFF_STACK, 32'h0123, IEXS_RESP_OKAY);
    wr(IEXS_OFF_STACK, 32'h1456, IEXS_RESP_OKAY);
    ex(OP_RETURN, 1'b0, 7'h00, 8'h00);
    rchk("pc", IEXS_OFF_PC, 32'h1456);
    rchk("status", IEXS_OFF_STATUS, 32'h18);
    ex(OP_RET_LIT, 1'b0, 7'h00, 8'h77);
    rchk("pc", IEXS_OFF_PC, 32'h0123);
    rchk("acc", IEXS_OFF_ACC, 32'h77);
    wr(IEXS_OFF_STACK, 32'h0abc, IEXS_RESP_OKAY);
    ex(OP_RET_INT, 1'b0, 7'h00, 8'h00);
    rchk("pc", IEXS_OFF_PC, 32'h0abc);
    rchk("status", IEXS_OFF_STATUS, 32'h38);
  endtask
  task automatic t_sleep_nop();
    wr(IEXS_OFF_ACC, 32'h11, IEXS_RESP_OKAY);
    wr(IEXS_OFF_STATUS, 32'h08, IEXS_RESP_OKAY);
    ex(OP_SLEEP, 1'b0, 7'h00, 8'h00);
    rchk("status", IEXS_OFF_STATUS, 32'h50);
    rchk("wdog", IEXS_OFF_WDOG, 32'h0);
    chk("osc_run", 32'h0, {31'h0, osc_run});
    ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h33);
    rchk("acc", IEXS_OFF_ACC, 32'h11);
    wr(IEXS_OFF_STATUS, 32'h1f, IEXS_RESP_OKAY);
    chk("osc_run", 32'h1, {31'h0, osc_run});
    wr(IEXS_OFF_PC, 32'h1fff, IEXS_RESP_OKAY);
    ex(OP_NOP, 1'b0, 7'h00, 8'h00);
    rchk("pc", IEXS_OFF_PC, 32'h0);
    rchk("acc", IEXS_OFF_ACC, 32'h11);
    rchk("status", IEXS_OFF_STATUS, 32'h1f);
  endtask
  // ========================================
  // main sequence and watchdog
  initial begin
    aresetn <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    awaddr <= 32'h0;
    wdata <= 32'h0;
    wstrb <= 4'h0;
    araddr <= 32'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_load_store();
    t_rot_swap();
    t_arith();
    t_returns();
    t_sleep_nop();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    conclude();
  end
endmodule
